// file: bench/remote_mau_model.sv
`timescale 1ns/1ns
module remote_mau_model #(
    parameter int LP_GAP = 200
) (
    // Clock and control
    input wire logic core_clk,
    input wire logic linkOn,
    // Comparator outputs
    output logic sqStdPos,
    output logic sqStdNeg,
    output logic sqRedPos,
    output logic sqRedNeg,
    output logic sqTailPos,
    output logic sqTailNeg,
    output logic rxLinkPulse
);
    logic [5:0] sq = 6'h00;
    int lpCnt = 0;

    assign {sqStdPos, sqStdNeg, sqRedPos, sqRedNeg, sqTailPos, sqTailNeg} = sq;

    // Remote link pulse train
    initial rxLinkPulse = 1'b0;
    always @(posedge core_clk) begin
        lpCnt <= (lpCnt + 1) % LP_GAP;
        rxLinkPulse <= linkOn && lpCnt < 10;
    end

    // One crossing: level 2 standard, 1 reduced, 0 tail only
    task automatic hit(input bit pos, input int lvl);
        @(posedge core_clk);
        sq <= {pos && lvl == 2, !pos && lvl == 2, pos && lvl > 0, !pos && lvl > 0, pos, !pos};
        @(posedge core_clk);
        sq <= 6'h00;
    endtask

    // Positive then negative start gap cycles apart, positive again 5 cycles later, then a tail-level body every 5 cycles
    task automatic packet(input int lvl, input int gap, input int halfBits);
        hit(1'b1, lvl);
        repeat (gap - 2) @(posedge core_clk);
        hit(1'b0, lvl);
        repeat (3) @(posedge core_clk);
        hit(1'b1, lvl);
        for (int i = 0; i < halfBits; i++) begin
            repeat (3) @(posedge core_clk);
            hit(i[0], 0);
        end
        #1;
    endtask
endmodule

// file: bench/tp_xcvr_properties.sv
`timescale 1ns/1ns
module tp_xcvr_properties
    import tp_xcvr_pkg::*;
#(
    parameter int LINK_FAIL = 700,
    parameter int JAB_LIMIT = 300
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Receive side
    input wire logic sqTailPos,
    input wire logic sqTailNeg,
    input wire logic rxLinkPulse,
    input wire logic rxValid,
    input wire logic collision,
    // Transmit side and link indicator
    input wire logic txEnable,
    input wire logic txPos,
    input wire logic txNeg,
    input wire logic txPosDly,
    input wire logic txNegDly,
    input wire logic txPosOe_n,
    input wire logic txNegOe_n,
    input wire logic goodLinkLed_n
);
    int quietCnt;
    int txOnCnt;
    int linkGap;
    logic pulseDly;

    // Quiet, transmit-on and link-gap counters
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quietCnt <= 0;
            txOnCnt <= 0;
            linkGap <= 0;
            pulseDly <= 1'b0;
        end else begin
            quietCnt <= (sqTailPos || sqTailNeg) ? 0 : quietCnt + 1;
            txOnCnt <= txEnable ? txOnCnt + 1 : 0;
            linkGap <= (rxLinkPulse && !pulseDly) ? 0 : linkGap + 1;
            pulseDly <= rxLinkPulse;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    property p_dlyPos; txPosDly == $past(txPos, 5); endproperty
    a_dlyPos: assert property (p_dlyPos) else $error("delayed positive output wrong");
    property p_dlyNeg; txNegDly == $past(txNeg, 5); endproperty
    a_dlyNeg: assert property (p_dlyNeg) else $error("delayed negative output wrong");
    property p_oeSplit; $past(resetn, 2) |-> txPosOe_n != txNegOe_n; endproperty
    a_oeSplit: assert property (p_oeSplit) else $error("both or neither pair driven");
    property p_lpWidth;
        $rose(txPos) && !txEnable && !$past(txEnable) && !$past(txEnable, 2) |-> txPos[*8] ##1 txPos[*2] ##1 !txPos;
    endproperty
    a_lpWidth: assert property (p_lpWidth) else $error("link pulse width wrong");
    property p_collRx; $rose(txEnable) && rxValid && !goodLinkLed_n |-> ##[1:4] collision; endproperty
    a_collRx: assert property (p_collRx) else $error("collision not reported at once");
    property p_collTx; txEnable && $past(txEnable) && $rose(rxValid) |-> !collision[*8]; endproperty
    a_collTx: assert property (p_collTx) else $error("collision reported too early");
    property p_eopHold; $fell(rxValid) |-> quietCnt >= EOP_CYC; endproperty
    a_eopHold: assert property (p_eopHold) else $error("valid dropped too early");
    property p_eopEnd; quietCnt > EOP_CYC + 4 |-> !rxValid; endproperty
    a_eopEnd: assert property (p_eopEnd) else $error("valid held past end of packet");
    property p_jabCut; txOnCnt > JAB_LIMIT + 4 |-> !txPos && !txNeg; endproperty
    a_jabCut: assert property (p_jabCut) else $error("transmit not cut by jabber");
    property p_linkFail; linkGap > LINK_FAIL + 4 |-> goodLinkLed_n; endproperty
    a_linkFail: assert property (p_linkFail) else $error("link kept without pulses");
endmodule

bind twisted_pair_transceiver_logic tp_xcvr_properties #(.LINK_FAIL(LINK_FAIL), .JAB_LIMIT(JAB_LIMIT))
    u_tp_xcvr_properties (
    .core_clk(core_clk), .resetn(resetn), .sqTailPos(sqTailPos), .sqTailNeg(sqTailNeg), .rxLinkPulse(rxLinkPulse),
    .rxValid(rxValid), .collision(collision), .txEnable(txEnable), .txPos(txPos), .txNeg(txNeg),
    .txPosDly(txPosDly), .txNegDly(txNegDly), .txPosOe_n(txPosOe_n), .txNegOe_n(txNegOe_n),
    .goodLinkLed_n(goodLinkLed_n)
);

// file: bench/twisted_pair_transceiver_logic_tb.sv
`timescale 1ns/1ns
module twisted_pair_transceiver_logic_tb
    import tp_xcvr_pkg::*;
;
    localparam int LP = 200;
    localparam int LF = 700;
    localparam int JAB = 300;
    localparam int UNJ = 500;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic [STRAP_W-1:0] dataStrap = 16'h1000;
    logic [STRAP_W-1:0] addrStrap = 16'hFF7F;
    logic sqStdPos, sqStdNeg, sqRedPos, sqRedNeg, sqTailPos, sqTailNeg, rxLinkPulse;
    logic txEnable = 1'b0;
    logic txData = 1'b0;
    logic linkOn = 1'b0;
    logic rxValid, rxData, collision, txPos, txNeg, txPosDly, txNegDly, txPosOe_n, txNegOe_n;
    logic goodLinkLed_n, filterEnable;
    int errors = 0;
    int cmpCount = 0;
    int cycles = 0;

    twisted_pair_transceiver_logic #(.LP_PERIOD(LP), .LINK_FAIL(LF), .JAB_LIMIT(JAB), .UNJAB_TIME(UNJ))
        u_twisted_pair_transceiver_logic (
        .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .memoryDataStrap(dataStrap), .memoryAddressStrap(addrStrap),
        .sqStdPos(sqStdPos), .sqStdNeg(sqStdNeg), .sqRedPos(sqRedPos), .sqRedNeg(sqRedNeg),
        .sqTailPos(sqTailPos), .sqTailNeg(sqTailNeg), .rxLinkPulse(rxLinkPulse), .txEnable(txEnable),
        .txData(txData), .rxValid(rxValid), .rxData(rxData), .collision(collision), .txPos(txPos),
        .txNeg(txNeg), .txPosDly(txPosDly), .txNegDly(txNegDly), .txPosOe_n(txPosOe_n),
        .txNegOe_n(txNegOe_n), .goodLinkLed_n(goodLinkLed_n), .filterEnable(filterEnable)
    );
    remote_mau_model #(.LP_GAP(LP)) u_remote_mau_model (
        .core_clk(core_clk), .linkOn(linkOn), .sqStdPos(sqStdPos), .sqStdNeg(sqStdNeg), .sqRedPos(sqRedPos),
        .sqRedNeg(sqRedNeg), .sqTailPos(sqTailPos), .sqTailNeg(sqTailNeg), .rxLinkPulse(rxLinkPulse)
    );

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) txData <= txEnable && !txData;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            $display("ERROR timeout expected finish seen hang");
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic waitCyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rdReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e,
                         input string name);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        check(name, e, regRdData & m);
    endtask
    task automatic pkt(input int lvl, input int gap, input int n);
        u_remote_mau_model.packet(lvl, gap, n);
    endtask
    task automatic waitRise();
        repeat (2 * LP) begin
            waitCyc(1);
            if (txPos === 1'b1) break;
        end
    endtask

    initial begin
        int t0;
        int hbRise;
        int hbFirst;
        logic prevCol;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        waitCyc(3);
        check("filterEnable", 1, filterEnable);
        check("posOe", 0, txPosOe_n);
        check("negOe", 1, txNegOe_n);
        rdReg(CFG_B_ADDR, 8'hFF, CFG_B_RESET, "cfgB");
        rdReg(CFG_C_ADDR, 8'hFF, 8'h00, "cfgC");
        wrReg(2'h3, 8'hFF);
        rdReg(2'h3, 8'hFF, 8'h00, "unmapped");
        wrReg(CFG_C_ADDR, 8'h40);
        waitCyc(3);
        check("negOeShield", 0, txNegOe_n);
        check("posOeShield", 1, txPosOe_n);
        rdReg(CFG_C_ADDR, 8'h40, 8'h40, "cfgCBack");
        rdReg(STATUS_ADDR, 8'h20, 8'h20, "stShield");
        wrReg(CFG_C_ADDR, 8'h00);
        $display("test config done");
        pkt(2, 5, 20);
        check("rxNoLink", 0, rxValid);
        @(posedge core_clk) linkOn <= 1'b1;
        waitCyc(LP + 20);
        check("ledOn", 0, goodLinkLed_n);
        rdReg(STATUS_ADDR, 8'h01, 8'h01, "stLink");
        $display("test link up done");
        pkt(2, 20, 20);
        check("rxLate", 0, rxValid);
        pkt(1, 5, 20);
        check("rxLow", 0, rxValid);
        pkt(2, 5, 20);
        check("rxGood", 1, rxValid);
        check("rxData", 1, rxData);
        waitCyc(EOP_CYC + 6);
        check("rxEop", 0, rxValid);
        wrReg(CFG_B_ADDR, 8'h02);
        pkt(1, 5, 20);
        check("rxReduced", 1, rxValid);
        waitCyc(EOP_CYC + 6);
        wrReg(CFG_B_ADDR, 8'h00);
        $display("test squelch done");
        fork
            pkt(2, 5, 30);
            begin
                waitCyc(40);
                @(posedge core_clk) txEnable <= 1'b1;
                waitCyc(4);
                check("colRx", 1, collision);
                waitCyc(40);
                check("colHold", 1, collision);
                @(posedge core_clk) txEnable <= 1'b0;
                waitCyc(6);
                check("colEnd", 0, collision);
            end
        join
        waitCyc(300);
        @(posedge core_clk) txEnable <= 1'b1;
        fork
            pkt(2, 5, 24);
            begin
                repeat (40) begin
                    if (rxValid === 1'b1) break;
                    waitCyc(1);
                end
                waitCyc(60);
                check("colDefer", 0, collision);
                waitCyc(16);
                check("colLate", 1, collision);
            end
        join
        @(posedge core_clk) txEnable <= 1'b0;
        hbRise = 0;
        hbFirst = 0;
        prevCol = 1'b1;
        for (int i = 0; i < 250; i++) begin
            waitCyc(1);
            if (i > 10 && collision === 1'b1 && prevCol === 1'b0) begin
                hbRise++;
                if (hbFirst == 0) hbFirst = i;
            end
            prevCol = collision;
        end
        check("hbCount", HB_CYCLES, hbRise);
        check("hbStart", 1, hbFirst >= HB_DELAY_CYC - 5 && hbFirst <= HB_DELAY_CYC + 12);
        $display("test collision done");
        waitRise();
        waitCyc(20);
        waitRise();
        t0 = cycles;
        waitCyc(20);
        waitRise();
        check("lpPeriod", LP, cycles - t0);
        $display("test link pulse done");
        waitCyc(20);
        @(posedge core_clk) txEnable <= 1'b1;
        waitCyc(JAB + 20);
        rdReg(STATUS_ADDR, 8'h08, 8'h08, "jabSet");
        check("jabTx", 0, txPos | txNeg);
        @(posedge core_clk) txEnable <= 1'b0;
        waitCyc(UNJ - 60);
        rdReg(STATUS_ADDR, 8'h08, 8'h08, "jabHold");
        waitCyc(80);
        rdReg(STATUS_ADDR, 8'h08, 8'h00, "jabClear");
        $display("test jabber done");
        @(posedge core_clk) linkOn <= 1'b0;
        waitCyc(LF + 20);
        check("ledFail", 1, goodLinkLed_n);
        pkt(2, 5, 10);
        check("rxFail", 0, rxValid);
        wrReg(CFG_B_ADDR, 8'h01);
        pkt(2, 5, 10);
        check("rxBypass", 1, rxValid);
        @(posedge core_clk) linkOn <= 1'b1;
        waitCyc(LP + 20);
        check("ledBack", 0, goodLinkLed_n);
        $display("test link fail done");
        summarize();
    end
endmodule

// file: verilog/tp_xcvr_pkg.sv
package tp_xcvr_pkg;
    // Clock rate
    localparam int CLK_MHZ = 100;
    // Timing figures as printed and their cycle counts
    localparam int SQ_WINDOW_NS = 150;
    localparam int SQ_WINDOW_CYC = (SQ_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int EOP_NS = 150;
    localparam int EOP_CYC = (EOP_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT_NS = 100;
    localparam int COL_BITS = 7;
    localparam int COL_DEFER_CYC = (COL_BITS * BIT_NS * CLK_MHZ + 999) / 1000;
    localparam int HB_DELAY_NS = 1000;
    localparam int HB_DELAY_CYC = (HB_DELAY_NS * CLK_MHZ) / 1000;
    localparam int HB_FREQ_MHZ = 10;
    localparam int HB_CYCLES = 10;
    localparam int HB_HALF_CYC = CLK_MHZ / (2 * HB_FREQ_MHZ);
    localparam int HB_EDGES = 2 * HB_CYCLES;
    localparam int LP_WIDTH_NS = 100;
    localparam int LP_WIDTH_CYC = (LP_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int LP_PERIOD_MS = 16;
    localparam int LP_PERIOD_CYC = LP_PERIOD_MS * CLK_MHZ * 1000;
    localparam int LINK_FAIL_MS = 64;
    localparam int LINK_FAIL_CYC = LINK_FAIL_MS * CLK_MHZ * 1000;
    localparam int JAB_MS = 26;
    localparam int JAB_CYC = JAB_MS * CLK_MHZ * 1000;
    localparam int UNJAB_MS = 750;
    localparam int UNJAB_CYC = UNJAB_MS * CLK_MHZ * 1000;
    localparam int PREEMPH_NS = 50;
    localparam int PREEMPH_CYC = (PREEMPH_NS * CLK_MHZ) / 1000;
    // Strap positions
    localparam int STRAP_W = 16;
    localparam int STRAP_FILTER_POS = 12;
    localparam int STRAP_SHIELD_POS = 7;
    // Register map
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] CFG_B_ADDR = 2'h0;
    localparam logic [ADDR_W-1:0] CFG_C_ADDR = 2'h1;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 2'h2;
    localparam int CFGB_LINK_DIS_POS = 0;
    localparam int CFGB_REDUCED_SQ_POS = 1;
    localparam int CFGC_SHIELDED_POS = 6;
    localparam int ST_LINK_OK_POS = 0;
    localparam int ST_RX_VALID_POS = 1;
    localparam int ST_COLLISION_POS = 2;
    localparam int ST_JABBER_POS = 3;
    localparam int ST_FILTER_POS = 4;
    localparam int ST_SHIELDED_POS = 5;
    localparam int ST_TX_ACTIVE_POS = 6;
    localparam logic [DATA_W-1:0] CFG_B_RESET = 8'h00;
    // Squelch states
    typedef enum logic [3:0] {
        SQ_IDLE = 4'b0001,
        SQ_OPPOSITE = 4'b0010,
        SQ_ORIGINAL = 4'b0100,
        SQ_VALID = 4'b1000
    } sq_state_type;
endpackage

// file: verilog/twisted_pair_transceiver_logic.sv
`timescale 1ns/1ns
module twisted_pair_transceiver_logic
    import tp_xcvr_pkg::*;
#(
    parameter int LP_PERIOD = LP_PERIOD_CYC,
    parameter int LINK_FAIL = LINK_FAIL_CYC,
    parameter int JAB_LIMIT = JAB_CYC,
    parameter int UNJAB_TIME = UNJAB_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    // Configuration straps
    input wire logic [STRAP_W-1:0] memoryDataStrap,
    input wire logic [STRAP_W-1:0] memoryAddressStrap,
    // Receive comparators
    input wire logic sqStdPos,
    input wire logic sqStdNeg,
    input wire logic sqRedPos,
    input wire logic sqRedNeg,
    input wire logic sqTailPos,
    input wire logic sqTailNeg,
    input wire logic rxLinkPulse,
    // Encoder side
    input wire logic txEnable,
    input wire logic txData,
    output logic rxValid,
    output logic rxData,
    output logic collision,
    // Transmit pins
    output logic txPos,
    output logic txNeg,
    output logic txPosDly,
    output logic txNegDly,
    output logic txPosOe_n,
    output logic txNegOe_n,
    // Indicators
    output logic goodLinkLed_n,
    output logic filterEnable
);
    localparam int BIGW = 32;

    if (LP_PERIOD < 2 || LINK_FAIL <= LP_PERIOD || JAB_LIMIT < 2 || UNJAB_TIME < 2) begin : g_check
        $error("twisted_pair_transceiver_logic: timing parameters out of range");
    end

    // Configuration registers and straps
    logic [DATA_W-1:0] cfgB_r;
    logic shielded_r;
    logic filter_r;
    logic strapDone_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            strapDone_r <= 1'b0;
            filter_r <= 1'b0;
            shielded_r <= 1'b0;
            cfgB_r <= CFG_B_RESET;
        end else begin
            strapDone_r <= 1'b1;
            if (!strapDone_r) begin
                filter_r <= memoryDataStrap[STRAP_FILTER_POS];
                shielded_r <= memoryAddressStrap[STRAP_SHIELD_POS];
            end else if (regWr && regAddr == CFG_C_ADDR) begin
                shielded_r <= regWrData[CFGC_SHIELDED_POS];
            end
            if (regWr && regAddr == CFG_B_ADDR) begin
                cfgB_r <= regWrData;
            end
        end
    end

    logic linkDisable;
    logic reducedSq;
    assign linkDisable = cfgB_r[CFGB_LINK_DIS_POS];
    assign reducedSq = cfgB_r[CFGB_REDUCED_SQ_POS];

    // Link integrity
    logic linkOk_r;
    logic [BIGW-1:0] linkCnt_r;
    logic lpPrev_r;
    logic linkPass;
    logic lpEdge;
    assign lpEdge = rxLinkPulse && !lpPrev_r;
    assign linkPass = linkOk_r || linkDisable;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lpPrev_r <= 1'b0;
            linkCnt_r <= '0;
            linkOk_r <= 1'b0;
        end else begin
            lpPrev_r <= rxLinkPulse;
            if (lpEdge) begin
                linkCnt_r <= '0;
                linkOk_r <= 1'b1;
            end else if (linkCnt_r >= BIGW'(LINK_FAIL - 1)) begin
                linkOk_r <= 1'b0;
            end else begin
                linkCnt_r <= linkCnt_r + 1'b1;
            end
        end
    end

    // Smart squelch
    sq_state_type sqState_r;
    logic firstPos_r;
    logic [7:0] sqCnt_r;
    logic levPos;
    logic levNeg;
    logic anyLev;

    always_comb begin
        if (sqState_r == SQ_VALID) begin
            levPos = sqTailPos;
            levNeg = sqTailNeg;
        end else if (reducedSq) begin
            levPos = sqRedPos;
            levNeg = sqRedNeg;
        end else begin
            levPos = sqStdPos;
            levNeg = sqStdNeg;
        end
    end
    assign anyLev = levPos || levNeg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sqState_r <= SQ_IDLE;
            firstPos_r <= 1'b0;
            sqCnt_r <= '0;
        end else if (!linkPass) begin
            sqState_r <= SQ_IDLE;
            sqCnt_r <= '0;
        end else begin
            unique case (sqState_r)
                SQ_IDLE: begin
                    sqCnt_r <= '0;
                    if (anyLev) begin
                        firstPos_r <= levPos;
                        sqState_r <= SQ_OPPOSITE;
                    end
                end
                SQ_OPPOSITE: begin
                    if ((firstPos_r && levNeg) || (!firstPos_r && levPos)) begin
                        sqCnt_r <= '0;
                        sqState_r <= SQ_ORIGINAL;
                    end else if (sqCnt_r >= 8'(SQ_WINDOW_CYC - 1)) begin
                        sqState_r <= SQ_IDLE;
                    end else begin
                        sqCnt_r <= sqCnt_r + 8'h01;
                    end
                end
                SQ_ORIGINAL: begin
                    if ((firstPos_r && levPos) || (!firstPos_r && levNeg)) begin
                        sqCnt_r <= '0;
                        sqState_r <= SQ_VALID;
                    end else if (sqCnt_r >= 8'(SQ_WINDOW_CYC - 1)) begin
                        sqState_r <= SQ_IDLE;
                    end else begin
                        sqCnt_r <= sqCnt_r + 8'h01;
                    end
                end
                SQ_VALID: begin
                    if (anyLev) begin
                        sqCnt_r <= '0;
                    end else if (sqCnt_r >= 8'(EOP_CYC)) begin
                        sqState_r <= SQ_IDLE;
                    end else begin
                        sqCnt_r <= sqCnt_r + 8'h01;
                    end
                end
                default: sqState_r <= SQ_IDLE;
            endcase
        end
    end

    logic rxActive;
    assign rxActive = (sqState_r == SQ_VALID);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rxValid <= 1'b0;
            rxData <= 1'b0;
        end else begin
            rxValid <= rxActive;
            rxData <= rxActive && sqTailPos;
        end
    end

    // Jabber
    logic jabbed_r;
    logic [BIGW-1:0] jabCnt_r;
    logic txActive;
    assign txActive = txEnable && !jabbed_r && linkPass;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            jabbed_r <= 1'b0;
            jabCnt_r <= '0;
        end else if (!jabbed_r) begin
            if (!txEnable) begin
                jabCnt_r <= '0;
            end else if (jabCnt_r >= BIGW'(JAB_LIMIT)) begin
                jabbed_r <= 1'b1;
                jabCnt_r <= '0;
            end else begin
                jabCnt_r <= jabCnt_r + 1'b1;
            end
        end else begin
            if (txEnable) begin
                jabCnt_r <= '0;
            end else if (jabCnt_r >= BIGW'(UNJAB_TIME - 1)) begin
                jabbed_r <= 1'b0;
                jabCnt_r <= '0;
            end else begin
                jabCnt_r <= jabCnt_r + 1'b1;
            end
        end
    end

    // Collision detect
    logic colCond;
    logic colPrev_r;
    logic txPrev_r;
    logic colDefer_r;
    logic colReport_r;
    logic [7:0] colCnt_r;
    assign colCond = rxActive && txActive;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            colPrev_r <= 1'b0;
            txPrev_r <= 1'b0;
            colDefer_r <= 1'b0;
            colReport_r <= 1'b0;
            colCnt_r <= '0;
        end else begin
            colPrev_r <= colCond;
            txPrev_r <= txActive;
            if (!colCond) begin
                colReport_r <= 1'b0;
                colDefer_r <= 1'b0;
                colCnt_r <= '0;
            end else if (!colPrev_r) begin
                colDefer_r <= txPrev_r;
                colReport_r <= !txPrev_r;
                colCnt_r <= 8'h01;
            end else if (colDefer_r) begin
                if (colCnt_r >= 8'(COL_DEFER_CYC - 1)) begin
                    colReport_r <= 1'b1;
                    colDefer_r <= 1'b0;
                end else begin
                    colCnt_r <= colCnt_r + 8'h01;
                end
            end
        end
    end

    // Heartbeat
    logic [7:0] hbCnt_r;
    logic [4:0] hbEdges_r;
    logic [2:0] hbDiv_r;
    logic hbWait_r;
    logic hbWave_r;
    logic hbTick;
    assign hbTick = (hbDiv_r == 3'(HB_HALF_CYC - 1));

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hbCnt_r <= '0;
            hbEdges_r <= '0;
            hbDiv_r <= '0;
            hbWait_r <= 1'b0;
            hbWave_r <= 1'b0;
        end else begin
            hbDiv_r <= hbTick ? 3'h0 : hbDiv_r + 3'h1;
            if (txPrev_r && !txActive) begin
                hbWait_r <= 1'b1;
                hbCnt_r <= '0;
                hbEdges_r <= '0;
                hbWave_r <= 1'b0;
            end else if (hbWait_r) begin
                if (hbCnt_r >= 8'(HB_DELAY_CYC - 1)) begin
                    hbWait_r <= 1'b0;
                    hbEdges_r <= 5'(HB_EDGES);
                end else begin
                    hbCnt_r <= hbCnt_r + 8'h01;
                end
            end else if (hbEdges_r != 5'h00 && hbTick) begin
                hbWave_r <= !hbWave_r;
                hbEdges_r <= hbEdges_r - 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            collision <= 1'b0;
        end else begin
            collision <= colReport_r || hbWave_r;
        end
    end

    // Link pulse generator
    logic [BIGW-1:0] lpCnt_r;
    logic [3:0] lpWidth_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lpCnt_r <= '0;
            lpWidth_r <= '0;
        end else if (txEnable) begin
            lpCnt_r <= '0;
            lpWidth_r <= '0;
        end else if (lpCnt_r >= BIGW'(LP_PERIOD - 1)) begin
            lpCnt_r <= '0;
            lpWidth_r <= 4'(LP_WIDTH_CYC);
        end else begin
            lpCnt_r <= lpCnt_r + 1'b1;
            if (lpWidth_r != 4'h0) begin
                lpWidth_r <= lpWidth_r - 4'h1;
            end
        end
    end

    // Transmit driver with pre-emphasis delay
    logic txTrue;
    logic txComp;
    logic [PREEMPH_CYC-1:0] dlyTrue_r;
    logic [PREEMPH_CYC-1:0] dlyComp_r;
    assign txTrue = txActive ? txData : (lpWidth_r != 4'h0);
    assign txComp = txActive && !txData;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dlyTrue_r <= '0;
            dlyComp_r <= '0;
            txPos <= 1'b0;
            txNeg <= 1'b0;
            txPosDly <= 1'b0;
            txNegDly <= 1'b0;
            txPosOe_n <= 1'b1;
            txNegOe_n <= 1'b1;
        end else begin
            dlyTrue_r <= {dlyTrue_r[PREEMPH_CYC-2:0], txTrue};
            dlyComp_r <= {dlyComp_r[PREEMPH_CYC-2:0], txComp};
            txPos <= txTrue;
            txNeg <= txComp;
            txPosDly <= dlyTrue_r[PREEMPH_CYC-1];
            txNegDly <= dlyComp_r[PREEMPH_CYC-1];
            txPosOe_n <= shielded_r;
            txNegOe_n <= !shielded_r;
        end
    end

    // Indicators and register reads
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            goodLinkLed_n <= 1'b1;
            filterEnable <= 1'b0;
            regRdData <= '0;
        end else begin
            goodLinkLed_n <= !linkOk_r;
            filterEnable <= filter_r;
            regRdData <= '0;
            if (regRd) begin
                unique case (regAddr)
                    CFG_B_ADDR: regRdData <= cfgB_r;
                    CFG_C_ADDR: regRdData <= DATA_W'(shielded_r) << CFGC_SHIELDED_POS;
                    STATUS_ADDR: begin
                        regRdData[ST_LINK_OK_POS] <= linkOk_r;
                        regRdData[ST_RX_VALID_POS] <= rxActive;
                        regRdData[ST_COLLISION_POS] <= colReport_r;
                        regRdData[ST_JABBER_POS] <= jabbed_r;
                        regRdData[ST_FILTER_POS] <= filter_r;
                        regRdData[ST_SHIELDED_POS] <= shielded_r;
                        regRdData[ST_TX_ACTIVE_POS] <= txActive;
                    end
                    default: regRdData <= '0;
                endcase
            end
        end
    end
endmodule
